// >>> logic/spicf_consts.svh
`ifndef SPICF_CONSTS_SVH
`define SPICF_CONSTS_SVH
// Register word addresses
`define SPICF_A_CTRL 3'h0
`define SPICF_A_BAUD 3'h1
`define SPICF_A_STAT 3'h2
`define SPICF_A_DATH 3'h3
`define SPICF_A_DATL 3'h4
// Control bit positions
`define SPICF_C_MASTER 0
`define SPICF_C_POL 1
`define SPICF_C_PHASE 2
`define SPICF_C_LSB_FIRST 3
`define SPICF_C_SEL_OUT_EN 4
`define SPICF_C_FAULT_EN 5
`define SPICF_C_FRAME16 6
// Baud field positions
`define SPICF_B_PRE_LSB 0
`define SPICF_B_RATE_LSB 4
// Status bit positions
`define SPICF_S_RX_FULL 7
`define SPICF_S_TX_EMPTY 5
`define SPICF_S_FAULT 4
// Reset values
`define SPICF_RST_CTRL 8'h00
`define SPICF_RST_BAUD 8'h00
`define SPICF_RST_SYNC 4'h2
// Edges per frame
`define SPICF_EDGES_8 6'h10
`define SPICF_EDGES_16 6'h20
`endif

// >>> logic/spicf_pkg.sv
package spicf_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_XFER = 2'b10,
        ST_TRAIL = 2'b11
    } spicf_state_e;
endpackage

// >>> logic/spicf_core.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "spicf_consts.svh"
module spicf_core (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_b_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_b_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_b_o,
    input wire logic ss_b_i,
    output logic ss_b_o,
    output logic ss_oe_b_o
);
    logic [7:0] ctrl;
    logic [7:0] baud;
    logic [15:0] tx_buf;
    logic tx_full;
    logic [7:0] hi_buf;
    logic got_hi;
    logic got_lo;
    logic [15:0] rx_data;
    logic rx_full;
    logic fault;
    logic fault_seen;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] flt;
    logic sclk_prev;
    logic ss_prev;
    spicf_pkg::spicf_state_e st;
    spicf_pkg::spicf_state_e next_st;
    logic [10:0] div_cnt;
    logic [10:0] half_div;
    logic [5:0] ecnt;
    logic [5:0] edge_no;
    logic [15:0] sh;
    logic [15:0] sh_next;
    logic [15:0] rx_next;
    logic [15:0] ld_val;
    logic samp;
    logic dout;
    logic sclk_lvl;
    logic master;
    logic pol;
    logic phase;
    logic lsbf;
    logic f16;
    logic auto_ss;
    logic sclk_f;
    logic ss_f;
    logic mosi_f;
    logic miso_f;
    logic din;
    logic tick;
    logic m_edge;
    logic s_edge;
    logic edge_evt;
    logic last;
    logic done;
    logic smp_edge;
    logic start_m;
    logic load;
    logic fault_det;
    logic ctrl_wr;
    logic cfg_chg;
    logic frm_chg;
    logic abort;
    logic ss_fall;

    // First bit presented for the current length and order
    function automatic logic first_bit(input logic [15:0] v, input logic lf, input logic w);
        first_bit = lf ? v[0] : (w ? v[15] : v[7]);
    endfunction

    // One shift, inserting the sampled bit at the far end
    function automatic logic [15:0] shift1(input logic [15:0] v, input logic b,
                                           input logic lf, input logic w);
        if (lf) begin
            shift1 = w ? {b, v[15:1]} : {8'h00, b, v[7:1]};
        end else begin
            shift1 = {v[14:0], b};
        end
    endfunction

    assign master = ctrl[`SPICF_C_MASTER];
    assign pol = ctrl[`SPICF_C_POL];
    assign phase = ctrl[`SPICF_C_PHASE];
    assign lsbf = ctrl[`SPICF_C_LSB_FIRST];
    assign f16 = ctrl[`SPICF_C_FRAME16];
    assign auto_ss = master & ctrl[`SPICF_C_SEL_OUT_EN] & ctrl[`SPICF_C_FAULT_EN];
    assign {miso_f, mosi_f, ss_f, sclk_f} = flt;

    // Pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sy1 <= `SPICF_RST_SYNC;
            sy2 <= `SPICF_RST_SYNC;
            sy3 <= `SPICF_RST_SYNC;
            flt <= `SPICF_RST_SYNC;
        end else begin
            sy1 <= {miso_i, mosi_i, ss_b_i, sclk_i};
            sy2 <= sy1;
            sy3 <= sy2;
            flt <= ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & flt);
        end
    end

    // Previous filtered levels for edge detection
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_prev <= 1'b0;
            ss_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk_f;
            ss_prev <= ss_f;
        end
    end

    // Control decode; any master config change aborts the frame
    assign ctrl_wr = wr_i && addr_i == `SPICF_A_CTRL;
    assign frm_chg = master && ctrl_wr && wdata_i[`SPICF_C_FRAME16] != f16;
    assign cfg_chg = master && ((ctrl_wr && wdata_i != ctrl) ||
                     (wr_i && addr_i == `SPICF_A_BAUD && wdata_i != baud));
    assign fault_det = master && ctrl[`SPICF_C_FAULT_EN] && !ctrl[`SPICF_C_SEL_OUT_EN]
                       && !ss_f;
    assign abort = fault_det || cfg_chg;

    // Half-period length: divisor over two
    assign half_div = ({8'h00, baud[`SPICF_B_PRE_LSB +: 3]} + 11'h001)
                      << baud[`SPICF_B_RATE_LSB +: 3];
    assign tick = st != spicf_pkg::ST_IDLE && div_cnt == half_div - 11'h001;

    // Edge bookkeeping shared by both roles
    assign m_edge = (st == spicf_pkg::ST_LEAD || st == spicf_pkg::ST_XFER) && tick; // Lead ends in edge one
    assign s_edge = !master && !ss_f && sclk_f != sclk_prev; // select high ignores clock
    assign edge_evt = m_edge || s_edge;
    assign edge_no = ecnt + 6'h01;
    assign last = edge_no == (f16 ? `SPICF_EDGES_16 : `SPICF_EDGES_8);
    assign smp_edge = edge_no[0] ^ phase;
    assign done = edge_evt && last;
    assign din = master ? miso_f : mosi_f;
    assign sh_next = shift1(sh, samp, lsbf, f16);
    // Phase 1 ends on a sample edge, so the live input is the last bit
    assign rx_next = shift1(sh, phase ? din : samp, lsbf, f16);
    assign ss_fall = !master && ss_prev && !ss_f;
    assign start_m = st == spicf_pkg::ST_IDLE && master && tx_full && !fault && !abort;
    assign load = start_m || ss_fall || (!master && done && !ss_f);
    assign ld_val = tx_full ? tx_buf : (done ? rx_next : sh);

    // Master sequencer: lead half, edges, trail half
    always_comb begin
        next_st = st;
        unique case (st)
            spicf_pkg::ST_IDLE: begin
                if (start_m) begin
                    next_st = spicf_pkg::ST_LEAD;
                end
            end
            spicf_pkg::ST_LEAD: begin
                if (tick) begin
                    next_st = spicf_pkg::ST_XFER;
                end
            end
            spicf_pkg::ST_XFER: begin
                if (done) begin
                    next_st = spicf_pkg::ST_TRAIL;
                end
            end
            spicf_pkg::ST_TRAIL: begin
                if (tick) begin
                    next_st = spicf_pkg::ST_IDLE;
                end
            end
        endcase
        if (abort || !master) begin
            next_st = spicf_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= spicf_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Divider held cleared when idle to save power
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt <= 11'h000;
        end else if (st == spicf_pkg::ST_IDLE || tick || abort) begin
            div_cnt <= 11'h000;
        end else begin
            div_cnt <= div_cnt + 11'h001;
        end
    end

    // Clock level toggles per edge; polarity only inverts it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_lvl <= 1'b0;
        end else if (st == spicf_pkg::ST_IDLE || abort) begin
            sclk_lvl <= 1'b0;
        end else if (m_edge) begin
            sclk_lvl <= ~sclk_lvl;
        end
    end

    // Shifter: load, sample on one edge kind, shift on the other except edge one in phase 1
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sh <= 16'h0000;
            ecnt <= 6'h00;
            samp <= 1'b0;
            dout <= 1'b0;
        end else if (abort || (!master && ss_f)) begin
            ecnt <= 6'h00;
        end else if (load) begin
            sh <= ld_val;
            ecnt <= 6'h00;
            dout <= first_bit(ld_val, lsbf, f16);
        end else if (edge_evt) begin
            ecnt <= edge_no;
            if (done) begin
                sh <= rx_next;
                ecnt <= 6'h00;
            end else if (smp_edge) begin
                samp <= din;
            end else if (phase && edge_no == 6'h01) begin
                dout <= first_bit(sh, lsbf, f16);
            end else begin
                sh <= sh_next;
                dout <= first_bit(sh_next, lsbf, f16);
            end
        end
    end

    // Control and baud registers; fault drops master mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= `SPICF_RST_CTRL;
            baud <= `SPICF_RST_BAUD;
        end else begin
            if (ctrl_wr) begin
                ctrl <= wdata_i;
            end
            if (wr_i && addr_i == `SPICF_A_BAUD) begin
                baud <= wdata_i;
            end
            if (fault_det) begin
                ctrl[`SPICF_C_MASTER] <= 1'b0;
            end
        end
    end

    // Fault flag: status read while set, then control write, clears it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault <= 1'b0;
            fault_seen <= 1'b0;
        end else if (fault_det) begin
            fault <= 1'b1;
        end else if (frm_chg) begin
            fault <= 1'b0;
            fault_seen <= 1'b0;
        end else if (ctrl_wr && fault_seen) begin
            fault <= 1'b0;
            fault_seen <= 1'b0;
        end else if (rd_i && addr_i == `SPICF_A_STAT && fault) begin
            fault_seen <= 1'b1;
        end
    end

    // Transmit buffer; 16-bit words move only once both bytes arrive
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_buf <= 16'h0000;
            tx_full <= 1'b0;
            hi_buf <= 8'h00;
            got_hi <= 1'b0;
            got_lo <= 1'b0;
        end else if (frm_chg) begin
            tx_full <= 1'b0;
            got_hi <= 1'b0;
            got_lo <= 1'b0;
        end else if (load && tx_full) begin
            tx_full <= 1'b0;
        end else if (wr_i && !tx_full && !f16 && addr_i == `SPICF_A_DATL) begin
            tx_buf <= {8'h00, wdata_i};
            tx_full <= 1'b1;
        end else if (wr_i && !tx_full && f16 && addr_i == `SPICF_A_DATH) begin
            hi_buf <= wdata_i;
            got_hi <= 1'b0;
            got_lo <= 1'b0;
            if (got_lo) begin
                tx_buf <= {wdata_i, tx_buf[7:0]};
                tx_full <= 1'b1;
            end else begin
                got_hi <= 1'b1;
            end
        end else if (wr_i && !tx_full && f16 && addr_i == `SPICF_A_DATL) begin
            tx_buf[7:0] <= wdata_i;
            got_lo <= 1'b0;
            got_hi <= 1'b0;
            if (got_hi) begin
                tx_buf[15:8] <= hi_buf;
                tx_full <= 1'b1;
            end else begin
                got_lo <= 1'b1;
            end
        end
    end

    // Receive word; completion wins over the clearing read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_data <= 16'h0000;
            rx_full <= 1'b0;
        end else if (frm_chg) begin
            rx_full <= 1'b0;
        end else if (done) begin
            rx_data <= f16 ? rx_next : {8'h00, rx_next[7:0]};
            rx_full <= 1'b1;
        end else if (rd_i && addr_i == `SPICF_A_DATL) begin
            rx_full <= 1'b0;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (!rd_i) begin
            rdata_o <= 8'h00;
        end else begin
            unique case (addr_i)
                `SPICF_A_CTRL: rdata_o <= ctrl;
                `SPICF_A_BAUD: rdata_o <= baud;
                `SPICF_A_STAT: rdata_o <= {rx_full, 1'b0, ~tx_full, fault, 4'h0};
                `SPICF_A_DATH: rdata_o <= f16 ? rx_data[15:8] : 8'h00;
                `SPICF_A_DATL: rdata_o <= rx_data[7:0];
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // Pin drivers; a fault leaves every pin released
    assign sclk_o = pol ^ sclk_lvl;
    assign sclk_oe_b_o = ~master;
    assign mosi_o = dout;
    assign mosi_oe_b_o = ~master;
    assign miso_o = dout;
    assign miso_oe_b_o = ~(!master && !ss_f && !fault);
    assign ss_b_o = ~(st != spicf_pkg::ST_IDLE);
    assign ss_oe_b_o = ~auto_ss;
endmodule
`default_nettype wire

// >>> dv/spicf_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "spicf_consts.svh"
module spicf_monitor (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic sclk_i,
    input wire logic sclk_o,
    input wire logic sclk_oe_b_o,
    input wire logic mosi_i,
    input wire logic mosi_o,
    input wire logic mosi_oe_b_o,
    input wire logic miso_i,
    input wire logic miso_o,
    input wire logic miso_oe_b_o,
    input wire logic ss_b_i,
    input wire logic ss_b_o,
    input wire logic ss_oe_b_o
);
    logic [7:0] sh_c;
    logic [7:0] sh_b;
    logic [10:0] hh;
    logic [11:0] hc;
    logic [5:0] ec;
    logic sp;
    logic ab;
    logic tg;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Shadow settings, since only the pins are visible here
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sh_c <= `SPICF_RST_CTRL;
            sh_b <= `SPICF_RST_BAUD;
        end else if (wr_i) begin
            if (addr_i == `SPICF_A_CTRL) sh_c <= wdata_i;
            if (addr_i == `SPICF_A_BAUD) sh_b <= wdata_i;
        end
    end
    // Expected half period and clock toggle seen this cycle
    assign hh = ({8'h00, sh_b[2:0]} + 11'h001) << sh_b[6:4];
    assign tg = sclk_o != sp;
    // Per-frame counters; a settings write mid-frame marks it aborted
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp <= 1'b0;
            hc <= 12'h000;
            ec <= 6'h00;
            ab <= 1'b0;
        end else begin
            sp <= sclk_o;
            if (ss_b_o) begin
                hc <= 12'h000;
                ec <= 6'h00;
                ab <= 1'b0;
            end else begin
                hc <= tg ? 12'h001 : hc + 12'h001;
                ec <= ec + {5'h00, tg};
                if (wr_i && addr_i < 3'h2) ab <= 1'b1;
            end
        end
    end
    a_idle_clock_level: assert property (
        ss_b_o && !sclk_oe_b_o |-> sclk_o == sh_c[`SPICF_C_POL])
        else $error("serial clock left its idle level");
    a_sel_out_gate: assert property (
        ss_oe_b_o == !(sh_c[`SPICF_C_MASTER] && sh_c[`SPICF_C_SEL_OUT_EN] &&
        sh_c[`SPICF_C_FAULT_EN]))
        else $error("select output enable wrong");
    a_half_period: assert property (
        tg && !ss_b_o && !sclk_oe_b_o && !ab |-> hc == {1'b0, hh})
        else $error("half period differs from divisor");
    a_frame_edge_count: assert property (
        $rose(ss_b_o) && !sclk_oe_b_o && !ab |-> ec == (sh_c[`SPICF_C_FRAME16] ?
        `SPICF_EDGES_16 : `SPICF_EDGES_8) && hc >= {1'b0, hh} && hc <= {1'b0, hh} + 12'h001)
        else $error("frame edge count or select release wrong");
    a_clock_in_frame: assert property (
        tg && !sclk_oe_b_o && !$past(wr_i) |-> !ss_b_o)
        else $error("serial clock moved with select high");
    a_fault_trip: assert property (
        (sh_c[0] && sh_c[5] && !sh_c[4] && !ss_b_i) [*8] |-> sclk_oe_b_o && mosi_oe_b_o)
        else $error("mode fault did not release pins");
    a_fault_off: assert property (
        (sh_c[0] && sh_c[4] && sh_c[5] && !ss_b_i) [*8] |-> !sclk_oe_b_o)
        else $error("fault tripped with select output on");
    a_slave_drive: assert property (
        (!sh_c[0] && !ss_b_i) [*6] |-> !miso_oe_b_o)
        else $error("selected slave not driving");
    a_slave_quiet: assert property (
        (!sh_c[0] && ss_b_i) [*6] |-> miso_oe_b_o)
        else $error("unselected slave driving");
endmodule
`default_nettype wire

// >>> dv/spicf_peer.sv
`timescale 1ns/100ps
`default_nettype none
module spicf_peer (
    input wire logic sclk_i,
    input wire logic ss_b_i,
    input wire logic mosi_i,
    input wire logic pha_i,
    input wire logic lsb_i,
    input wire logic w16_i,
    input wire logic [15:0] tx_i,
    output logic miso_o,
    output logic [15:0] rx_o
);
    int e = 0;
    int n = 8;
    int b;
    function automatic int idx(input int i);
        return lsb_i ? i : n - 1 - i;
    endfunction
    initial miso_o = 1'b0;
    initial rx_o = 16'h0000;
    // Selection restarts the count; phase 1 data stays undefined until edge one
    always @(negedge ss_b_i) begin
        e = 0;
        n = w16_i ? 16 : 8;
        miso_o = pha_i ? ~miso_o : tx_i[idx(0)];
    end
    // Released line flips rather than holding a stale bit
    always @(posedge ss_b_i) miso_o = ~miso_o;
    // Sample edges capture mosi, the others present the next bit
    always @(sclk_i) begin
        if (!ss_b_i) begin
            e = e + 1;
            b = pha_i ? (e - 1) / 2 : e / 2;
            if ((e % 2 == 1) != pha_i) rx_o[idx((e - 1) / 2)] = mosi_i;
            else if (b < n) miso_o = tx_i[idx(b)];
        end
    end
endmodule
`default_nettype wire

// >>> dv/spicf_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "spicf_consts.svh"
module spicf_core_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tb_sclk = 1'b0;
    logic tb_mosi = 1'b0;
    logic tb_ss = 1'b1;
    logic p_pha = 1'b0;
    logic p_lsb = 1'b0;
    logic p_16 = 1'b0;
    logic [15:0] p_tx = 16'h0000;
    logic [15:0] p_rx;
    logic [7:0] rdata;
    logic sclk_o, sclk_oe_b, mosi_o, mosi_oe_b, miso_o, miso_oe_b, ss_o, ss_oe_b, p_miso;
    int error_cnt = 0;
    int checks = 0;
    // Pin levels resolved from every driver's enable
    wire logic sclk_w = sclk_oe_b ? tb_sclk : sclk_o;
    wire logic mosi_w = mosi_oe_b ? tb_mosi : mosi_o;
    wire logic miso_w = miso_oe_b ? p_miso : miso_o;
    wire logic ss_w = ss_oe_b ? tb_ss : ss_o;
    always #20 clk = ~clk;
    spicf_core dut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_b_o(sclk_oe_b),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_b_o(mosi_oe_b), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe_b_o(miso_oe_b), .ss_b_i(ss_w), .ss_b_o(ss_o),
        .ss_oe_b_o(ss_oe_b));
    spicf_peer u_peer (.sclk_i(sclk_w), .ss_b_i(ss_w), .mosi_i(mosi_w), .pha_i(p_pha),
        .lsb_i(p_lsb), .w16_i(p_16), .tx_i(p_tx), .miso_o(p_miso), .rx_o(p_rx));
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe edge
    task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] ex);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, {8'h00, ex}, {8'h00, rdata});
    endtask
    task automatic wait_ss(input logic v);
        for (int i = 0; i < 40000 && ss_o !== v; i++) begin
            @(posedge clk);
            #1;
        end
        chk("select out", {15'h0000, v}, {15'h0000, ss_o});
    endtask
    task automatic t_master(input logic [7:0] c, b, input logic [15:0] w, pw, input bit dc);
        logic [15:0] m;
        p_pha = c[2];
        p_lsb = c[3];
        p_16 = c[6];
        p_tx = pw;
        wreg(`SPICF_A_CTRL, c);
        wreg(`SPICF_A_BAUD, b);
        rchk("status", `SPICF_A_STAT, 8'h20);
        if (c[6]) wreg(`SPICF_A_DATH, w[15:8]);
        wreg(`SPICF_A_DATL, w[7:0]);
        wait_ss(1'b0);
        wait_ss(1'b1);
        m = c[6] ? 16'hFFFF : 16'h00FF;
        chk("peer rx", w & m, p_rx & m);
        rchk("status", `SPICF_A_STAT, 8'hA0);
        if (dc) rchk("data low", `SPICF_A_DATL, pw[7:0]);
        else rchk("data high", `SPICF_A_DATH, 8'h00);
        if (dc && c[6]) rchk("data high", `SPICF_A_DATH, pw[15:8]);
        $display("master test done");
    endtask
    // Frame length flipped mid-frame with a word waiting
    task automatic t_abort;
        wreg(`SPICF_A_BAUD, 8'h13);
        wreg(`SPICF_A_DATL, 8'h55);
        wait_ss(1'b0);
        wreg(`SPICF_A_DATL, 8'hAA);
        repeat (20) @(posedge clk);
        wreg(`SPICF_A_CTRL, 8'h71);
        repeat (12) @(posedge clk);
        #1 chk("select out", 16'h0001, {15'h0000, ss_o});
        rchk("status", `SPICF_A_STAT, 8'h20);
        $display("abort test done");
    endtask
    task automatic t_fault;
        @(posedge clk);
        tb_ss <= 1'b0;
        wreg(`SPICF_A_CTRL, 8'h21);
        repeat (10) @(posedge clk);
        #1 chk("clock enable", 16'h0001, {15'h0000, sclk_oe_b});
        rchk("status", `SPICF_A_STAT, 8'h30);
        rchk("control", `SPICF_A_CTRL, 8'h20);
        @(posedge clk);
        tb_ss <= 1'b1;
        repeat (6) @(posedge clk);
        wreg(`SPICF_A_CTRL, 8'h00);
        rchk("status", `SPICF_A_STAT, 8'h20);
        $display("fault test done");
    endtask
    // Bench plays master; half period of nine clocks covers input filtering
    task automatic t_slave(input logic pha, keep, cm, input logic [7:0] tx, rv);
        int b;
        wreg(`SPICF_A_DATL, tx);
        @(posedge clk);
        tb_ss <= 1'b0;
        tb_mosi <= pha ? 1'b0 : rv[7];
        repeat (8) @(posedge clk);
        for (int e = 1; e <= 16; e++) begin
            #1;
            if (cm && (e % 2 == 1) != pha)
                chk("slave out", 16'(tx[7 - (e - 1) / 2]), 16'(miso_o));
            @(posedge clk);
            tb_sclk <= ~tb_sclk;
            b = pha ? (e - 1) / 2 : e / 2;
            if ((e % 2 == 1) == pha && b < 8) tb_mosi <= rv[7 - b];
            repeat (8) @(posedge clk);
        end
        @(posedge clk);
        if (!keep) tb_ss <= 1'b1;
        repeat (6) @(posedge clk);
        rchk("slave rx", `SPICF_A_DATL, rv);
        $display("slave test done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rchk("control", `SPICF_A_CTRL, 8'h00);
        rchk("baud", `SPICF_A_BAUD, 8'h00);
        rchk("status", `SPICF_A_STAT, 8'h20);
        rchk("unmapped", 3'h5, 8'h00);
        $display("reset test done");
        t_master(8'h31, 8'h13, 16'h00A5, 16'h003C, 1'b1);
        t_master(8'h3B, 8'h07, 16'h0081, 16'h00E6, 1'b1);
        t_master(8'h7D, 8'h21, 16'h9C35, 16'h4DB2, 1'b1);
        t_master(8'h77, 8'h30, 16'hF00F, 16'h1248, 1'b1);
        t_master(8'h31, 8'h77, 16'h0033, 16'h0000, 1'b1);
        // Divisor two outruns the input filter, so the received word is not judged
        t_master(8'h31, 8'h00, 16'h00C4, 16'h0000, 1'b0);
        t_abort;
        t_fault;
        t_slave(1'b0, 1'b0, 1'b1, 8'hC3, 8'h5A);
        wreg(`SPICF_A_CTRL, 8'h04);
        t_slave(1'b1, 1'b1, 1'b1, 8'h96, 8'h3E);
        t_slave(1'b1, 1'b0, 1'b0, 8'h00, 8'hC1);
        give_verdict;
    end
    // Watchdog well past the expected run length
    initial begin
        #(40 * 90000);
        error_cnt++;
        give_verdict;
    end
endmodule
bind spicf_core spicf_monitor mon (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe_b_o(sclk_oe_b_o), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe_b_o(mosi_oe_b_o), .miso_i(miso_i), .miso_o(miso_o), .miso_oe_b_o(miso_oe_b_o),
    .ss_b_i(ss_b_i), .ss_b_o(ss_b_o), .ss_oe_b_o(ss_oe_b_o));
`default_nettype wire
